/* File: registered_bus_transceiver.sv */
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Two-half registered transceiver with an AHB-Lite register window
module registered_bus_transceiver (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Transfer size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Response, always OKAY
	input wire logic [xcvr_pkg::HALVES-1:0] a_to_b_drive_enable, // B drive, high
	input wire logic [xcvr_pkg::HALVES-1:0] b_to_a_drive_enable_n, // A drive, low
	input wire logic [xcvr_pkg::HALVES-1:0] a_to_b_source_select, // High sends stored A
	input wire logic [xcvr_pkg::HALVES-1:0] b_to_a_source_select, // High sends stored B
	input wire logic [xcvr_pkg::HALVES-1:0] a_capture_clock, // A store on rise
	input wire logic [xcvr_pkg::HALVES-1:0] b_capture_clock, // B store on rise
	input wire logic [xcvr_pkg::BUS_W-1:0] a_side_bus_in, // A pin levels
	input wire logic [xcvr_pkg::BUS_W-1:0] b_side_bus_in, // B pin levels
	output logic [xcvr_pkg::BUS_W-1:0] a_side_bus_out, // A drive values
	output logic [xcvr_pkg::BUS_W-1:0] b_side_bus_out, // B drive values
	output logic [xcvr_pkg::HALVES-1:0] a_side_bus_oe, // A drive per half
	output logic [xcvr_pkg::HALVES-1:0] b_side_bus_oe // B drive per half
);
	import xcvr_pkg::*;

	// Bus slave state
	phase_t phase;
	phase_t next_phase;
	logic [7:0] phase_addr;
	logic [7:0] next_phase_addr;
	logic [31:0] next_hrdata;
	logic next_hreadyout;
	logic next_hresp;

	// Software control state
	logic isolate;
	logic next_isolate;
	logic [HALVES-1:0] soft_cap_a;
	logic [HALVES-1:0] soft_cap_b;
	logic [HALVES-1:0] next_soft_cap_a;
	logic [HALVES-1:0] next_soft_cap_b;

	// Capture edges from the pins
	logic [HALVES-1:0] a_edge;
	logic [HALVES-1:0] b_edge;

	// Gathered half state for reads
	logic [BUS_W-1:0] a_store;
	logic [BUS_W-1:0] b_store;

	logic addr_taken;
	logic [31:0] read_value;

	// Pin clock rises, both kinds in one detector
	rise_detect #(.W(2 * HALVES)) u_rise (
		.hclk(hclk),
		.hresetn(hresetn),
		.level({b_capture_clock, a_capture_clock}),
		.pulse({b_edge, a_edge})
	);

	// Per-half datapaths
	for (genvar h = 0; h < HALVES; h++) begin : g_half
		half_if #(.W(HALF_W)) hb ();

		// Controls are taken per half; only isolate is shared by both halves
		assign hb.isolate = isolate;
		assign hb.oe_ab = a_to_b_drive_enable[h];
		assign hb.oe_ba_n = b_to_a_drive_enable_n[h];
		assign hb.sel_ab = a_to_b_source_select[h];
		assign hb.sel_ba = b_to_a_source_select[h];
		assign hb.cap_a = a_edge[h] | soft_cap_a[h];
		assign hb.cap_b = b_edge[h] | soft_cap_b[h];
		assign hb.a_in = a_side_bus_in[h*HALF_W +: HALF_W];
		assign hb.b_in = b_side_bus_in[h*HALF_W +: HALF_W];

		xcvr_half #(.W(HALF_W)) u_half (
			.hclk(hclk),
			.hresetn(hresetn),
			.hb(hb)
		);

		// Drivers are flops inside the half
		assign a_side_bus_out[h*HALF_W +: HALF_W] = hb.a_out;
		assign b_side_bus_out[h*HALF_W +: HALF_W] = hb.b_out;
		assign a_side_bus_oe[h] = hb.a_oe;
		assign b_side_bus_oe[h] = hb.b_oe;
		assign a_store[h*HALF_W +: HALF_W] = hb.a_reg;
		assign b_store[h*HALF_W +: HALF_W] = hb.b_reg;
	end

	// Address phase acceptance
	assign addr_taken = hsel && hready && (htrans == HTRANS_NONSEQ);

	// Read value chosen at the address phase
	always_comb begin
		read_value = RDATA_RESET;
		case (haddr[7:0])
			OFS_CTRL: begin
				read_value[CTRL_ISOLATE_BIT] = isolate;
			end
			OFS_AREG: begin
				read_value[BUS_W-1:0] = a_store;
			end
			OFS_BREG: begin
				read_value[BUS_W-1:0] = b_store;
			end
			OFS_STAT: begin
				read_value[STAT_A_OE_LSB +: HALVES] = a_side_bus_oe;
				read_value[STAT_B_OE_LSB +: HALVES] = b_side_bus_oe;
				read_value[STAT_ISOLATE_BIT] = isolate;
			end
			default: begin
				read_value = RDATA_RESET;
			end
		endcase
	end

	// Phase tracking and read data
	always_comb begin
		next_phase = PH_IDLE;
		next_phase_addr = phase_addr;
		next_hrdata = hrdata;
		next_hreadyout = 1'b1;
		next_hresp = HRESP_OKAY;
		if (addr_taken) begin
			next_phase_addr = haddr[7:0];
			if (hwrite && hsize == HSIZE_WORD) begin
				next_phase = PH_WRITE;
			end else if (!hwrite) begin
				next_phase = PH_READ;
				next_hrdata = read_value;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase <= PH_IDLE;
			phase_addr <= OFS_CTRL;
			hrdata <= RDATA_RESET;
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
		end else begin
			phase <= next_phase;
			phase_addr <= next_phase_addr;
			hrdata <= next_hrdata;
			hreadyout <= next_hreadyout;
			hresp <= next_hresp;
		end
	end

	// Write data phase effects
	always_comb begin
		next_isolate = isolate;
		next_soft_cap_a = '0;
		next_soft_cap_b = '0;
		case (phase)
			PH_WRITE: begin
				if (phase_addr == OFS_CTRL) begin
					next_isolate = hwdata[CTRL_ISOLATE_BIT];
				end
				if (phase_addr == OFS_CAPT) begin
					next_soft_cap_a = hwdata[CAPT_A_LSB +: HALVES];
					next_soft_cap_b = hwdata[CAPT_B_LSB +: HALVES];
				end
			end
			PH_READ: begin
				next_isolate = isolate;
			end
			PH_IDLE: begin
				next_isolate = isolate;
			end
			default: begin
				next_isolate = isolate;
			end
		endcase
	end

	// Control registers, isolation off after reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			isolate <= CTRL_ISOLATE_RESET;
			soft_cap_a <= '0;
			soft_cap_b <= '0;
		end else begin
			isolate <= next_isolate;
			soft_cap_a <= next_soft_cap_a;
			soft_cap_b <= next_soft_cap_b;
		end
	end

	// Read address phase then data phase
	sequence rd_areg;
		addr_taken && !hwrite && haddr[7:0] == OFS_AREG;
	endsequence

	sequence wr_ctrl;
		addr_taken && hwrite && hsize == HSIZE_WORD && haddr[7:0] == OFS_CTRL ##1 1'b1;
	endsequence

	sequence wr_capt_a0;
		addr_taken && hwrite && hsize == HSIZE_WORD && haddr[7:0] == OFS_CAPT
			##1 hwdata[CAPT_A_LSB];
	endsequence

	AST_READ_AREG: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_areg |=> hrdata == {16'h0000, $past(a_store)}) else $error("A store read wrong");
	AST_CTRL_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_ctrl |=> isolate == $past(hwdata[CTRL_ISOLATE_BIT])) else $error("Isolate not set");
	AST_SOFT_CAPTURE: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_capt_a0 |=> ##1 a_store[HALF_W-1:0] == $past(a_side_bus_in[HALF_W-1:0]))
		else $error("Software capture lost");
	AST_ISOLATE_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
		isolate |=> (a_side_bus_oe == '0 && b_side_bus_oe == '0)) else $error("Drove isolated");
	AST_ALWAYS_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
		hreadyout && hresp == HRESP_OKAY) else $error("Slave stalled or erred");
endmodule
`default_nettype wire

/* File: xcvr_pkg.sv */
// Notes on behaviour
// - Two independent 8-bit halves form one 16-bit non-inverting A/B transceiver.
// - Rising A capture clock stores the A bus; rising B capture clock stores B.
// - Capture ignores the drive enables; pin levels are stored on every rising clock.
// - A-to-B enable active high, B-to-A enable active low; both off isolates.
// - Capturing A leaves the B register holding; driven B value then unspecified.
// - Capturing B leaves the A register holding; driven A value then unspecified.
// - Driving A from B: select low passes live B, high sends stored B.
// - Driving B from A: select low passes live A, high sends stored A.
// - Both enables active and both selects high drive both buses from storage.
// - Selects pick live or stored data; enables pick which bus is driven unless isolate is set.
// - Every passed bit keeps its polarity, live or stored.
package xcvr_pkg;

	// Datapath shape
	localparam int HALVES = 2;
	localparam int HALF_W = 8;
	localparam int BUS_W = 16;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CAPT = 8'h04;
	localparam logic [7:0] OFS_AREG = 8'h08;
	localparam logic [7:0] OFS_BREG = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;

	// Field positions
	localparam int CTRL_ISOLATE_BIT = 0;
	localparam int CAPT_A_LSB = 0;
	localparam int CAPT_B_LSB = 2;
	localparam int STAT_A_OE_LSB = 0;
	localparam int STAT_B_OE_LSB = 2;
	localparam int STAT_ISOLATE_BIT = 4;

	// Values after reset
	localparam logic [HALF_W-1:0] STORE_RESET = 8'h00;
	localparam logic CTRL_ISOLATE_RESET = 1'b0;
	localparam logic [31:0] RDATA_RESET = 32'h00000000;

	// Bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [2:0] HSIZE_WORD = 3'b010;
	localparam logic HRESP_OKAY = 1'b0;

	// Data phase kinds
	typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ} phase_t;

endpackage

/* File: half_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Controls, pins and state of one transceiver half
interface half_if #(parameter int W = 8) ();
	logic isolate;
	logic oe_ab;
	logic oe_ba_n;
	logic sel_ab;
	logic sel_ba;
	logic cap_a;
	logic cap_b;
	logic [W-1:0] a_in;
	logic [W-1:0] b_in;
	logic [W-1:0] a_out;
	logic [W-1:0] b_out;
	logic a_oe;
	logic b_oe;
	logic [W-1:0] a_reg;
	logic [W-1:0] b_reg;
	modport core (input isolate, oe_ab, oe_ba_n, sel_ab, sel_ba, cap_a, cap_b, a_in, b_in,
		output a_out, b_out, a_oe, b_oe, a_reg, b_reg);
	modport ctrl (output isolate, oe_ab, oe_ba_n, sel_ab, sel_ba, cap_a, cap_b, a_in, b_in,
		input a_out, b_out, a_oe, b_oe, a_reg, b_reg);
endinterface
`default_nettype wire

/* File: rise_detect.sv */
`timescale 1ns/1ns
`default_nettype none
// Rising edge finder for capture clock levels sampled on hclk
module rise_detect #(parameter int W = 4) (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, low
	input wire logic [W-1:0] level, // Sampled levels
	output logic [W-1:0] pulse // One cycle per rise
);
	logic [W-1:0] prev;
	logic [W-1:0] next_prev;

	// Remember last level
	always_comb begin
		next_prev = level;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev <= '1;
		end else begin
			prev <= next_prev;
		end
	end

	// Starting high after reset hides a level that was already high
	assign pulse = level & ~prev;
endmodule
`default_nettype wire

/* File: xcvr_half.sv */
`timescale 1ns/1ns
`default_nettype none
// One 8-bit half: two stores and registered drivers for both buses
module xcvr_half
	import xcvr_pkg::*;
#(parameter int W = HALF_W) (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, low
	half_if.core hb // Controls and pins
);
	logic [W-1:0] next_a_reg;
	logic [W-1:0] next_b_reg;
	logic [W-1:0] next_a_out;
	logic [W-1:0] next_b_out;
	logic next_a_oe;
	logic next_b_oe;

	// Store updates and output selection
	always_comb begin
		next_a_reg = hb.cap_a ? hb.a_in : hb.a_reg;
		next_b_reg = hb.cap_b ? hb.b_in : hb.b_reg;
		next_b_out = hb.sel_ab ? hb.a_reg : hb.a_in;
		next_a_out = hb.sel_ba ? hb.b_reg : hb.b_in;
		next_b_oe = hb.oe_ab && !hb.isolate;
		next_a_oe = !hb.oe_ba_n && !hb.isolate;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hb.a_reg <= STORE_RESET;
			hb.b_reg <= STORE_RESET;
			hb.a_out <= STORE_RESET;
			hb.b_out <= STORE_RESET;
			hb.a_oe <= 1'b0;
			hb.b_oe <= 1'b0;
		end else begin
			hb.a_reg <= next_a_reg;
			hb.b_reg <= next_b_reg;
			hb.a_out <= next_a_out;
			hb.b_out <= next_b_out;
			hb.a_oe <= next_a_oe;
			hb.b_oe <= next_b_oe;
		end
	end

	// Capture then forward from storage
	sequence cap_then_stored;
		hb.cap_a ##1 (hb.sel_ab && !hb.cap_a);
	endsequence

	sequence both_stored;
		hb.oe_ab && !hb.oe_ba_n && hb.sel_ab && hb.sel_ba && !hb.isolate;
	endsequence

	AST_CAPTURE_A: assert property (@(posedge hclk) disable iff (!hresetn)
		hb.cap_a |=> hb.a_reg == $past(hb.a_in)) else $error("A store missed capture");
	AST_CAPTURE_B: assert property (@(posedge hclk) disable iff (!hresetn)
		hb.cap_b |=> hb.b_reg == $past(hb.b_in)) else $error("B store missed capture");
	AST_HOLD_A: assert property (@(posedge hclk) disable iff (!hresetn)
		!hb.cap_a |=> $stable(hb.a_reg)) else $error("A store changed without capture");
	AST_HOLD_B: assert property (@(posedge hclk) disable iff (!hresetn)
		!hb.cap_b |=> $stable(hb.b_reg)) else $error("B store changed without capture");
	AST_ISOLATE: assert property (@(posedge hclk) disable iff (!hresetn)
		(!hb.oe_ab && hb.oe_ba_n) |=> (!hb.a_oe && !hb.b_oe)) else $error("Isolation drove");
	AST_LIVE_B: assert property (@(posedge hclk) disable iff (!hresetn)
		(hb.oe_ab && !hb.sel_ab) |=> hb.b_out == $past(hb.a_in)) else $error("Live A lost");
	AST_STORED_A: assert property (@(posedge hclk) disable iff (!hresetn)
		hb.sel_ba |=> hb.a_out == $past(hb.b_reg)) else $error("Stored B not on A");
	AST_STORE_FORWARD: assert property (@(posedge hclk) disable iff (!hresetn)
		cap_then_stored |=> hb.b_out == $past(hb.a_in, 2)) else $error("Stored A altered");
	AST_BOTH_DRIVEN: assert property (@(posedge hclk) disable iff (!hresetn)
		both_stored |=> (hb.a_oe && hb.b_oe)) else $error("Both buses not driven");
endmodule
`default_nettype wire

/* File: bus_side_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Outside logic on the A and B buses; resolves every shared pin per half
module bus_side_model (
	input wire logic hclk, // System clock
	input wire logic [xcvr_pkg::BUS_W-1:0] a_val, // Value we put on A
	input wire logic [xcvr_pkg::BUS_W-1:0] b_val, // Value we put on B
	input wire logic [xcvr_pkg::HALVES-1:0] a_drv, // We drive A, per half
	input wire logic [xcvr_pkg::HALVES-1:0] b_drv, // We drive B, per half
	input wire logic [xcvr_pkg::BUS_W-1:0] a_out, // Device A values
	input wire logic [xcvr_pkg::BUS_W-1:0] b_out, // Device B values
	input wire logic [xcvr_pkg::HALVES-1:0] a_oe, // Device drives A
	input wire logic [xcvr_pkg::HALVES-1:0] b_oe, // Device drives B
	output logic [xcvr_pkg::BUS_W-1:0] a_pin, // Resolved A levels
	output logic [xcvr_pkg::BUS_W-1:0] b_pin // Resolved B levels
);
	import xcvr_pkg::*;
	logic [BUS_W-1:0] a_last = 16'h0000;
	logic [BUS_W-1:0] b_last = 16'h0000;

	// Contention is unknown; a released line flips every cycle
	function automatic logic [HALF_W-1:0] res(input logic doe, input logic pe,
		input logic [HALF_W-1:0] dv, input logic [HALF_W-1:0] pv, input logic [HALF_W-1:0] lv);
		if (doe && pe)
			return 8'hXX;
		if (doe)
			return dv;
		if (pe)
			return pv;
		return ~lv;
	endfunction

	// Wire resolution per half
	always_comb begin
		for (int h = 0; h < HALVES; h++) begin
			a_pin[h*HALF_W +: HALF_W] = res(a_oe[h], a_drv[h], a_out[h*HALF_W +: HALF_W],
				a_val[h*HALF_W +: HALF_W], a_last[h*HALF_W +: HALF_W]);
			b_pin[h*HALF_W +: HALF_W] = res(b_oe[h], b_drv[h], b_out[h*HALF_W +: HALF_W],
				b_val[h*HALF_W +: HALF_W], b_last[h*HALF_W +: HALF_W]);
		end
	end

	// Last levels seen on the wires
	always @(posedge hclk) begin
		a_last <= a_pin;
		b_last <= b_pin;
	end
endmodule
`default_nettype wire

/* File: registered_bus_transceiver_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module registered_bus_transceiver_tb;
	import xcvr_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [HALVES-1:0] oe_ab = 2'h0;
	logic [HALVES-1:0] oe_ba_n = 2'h3;
	logic [HALVES-1:0] sel_ab = 2'h0;
	logic [HALVES-1:0] sel_ba = 2'h0;
	logic [HALVES-1:0] cap_a = 2'h0;
	logic [HALVES-1:0] cap_b = 2'h0;
	logic [HALVES-1:0] a_drv = 2'h0;
	logic [HALVES-1:0] b_drv = 2'h0;
	logic [BUS_W-1:0] a_val = 16'h0000;
	logic [BUS_W-1:0] b_val = 16'h0000;
	logic [BUS_W-1:0] a_pin;
	logic [BUS_W-1:0] b_pin;
	logic [BUS_W-1:0] a_out;
	logic [BUS_W-1:0] b_out;
	logic [HALVES-1:0] a_oe;
	logic [HALVES-1:0] b_oe;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [31:0] scratch;

	// 250 MHz clock
	always #2 hclk = ~hclk;

	registered_bus_transceiver dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.a_to_b_drive_enable(oe_ab), .b_to_a_drive_enable_n(oe_ba_n),
		.a_to_b_source_select(sel_ab), .b_to_a_source_select(sel_ba),
		.a_capture_clock(cap_a), .b_capture_clock(cap_b), .a_side_bus_in(a_pin),
		.b_side_bus_in(b_pin), .a_side_bus_out(a_out), .b_side_bus_out(b_out),
		.a_side_bus_oe(a_oe), .b_side_bus_oe(b_oe));

	bus_side_model far_u (.hclk(hclk), .a_val(a_val), .b_val(b_val), .a_drv(a_drv),
		.b_drv(b_drv), .a_out(a_out), .b_out(b_out), .a_oe(a_oe), .b_oe(b_oe),
		.a_pin(a_pin), .b_pin(b_pin));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Hang guard
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			print_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// Wait for the slave to be ready at a rising edge
	task automatic wait_rdy();
		do begin
			@(posedge hclk);
		end while (hreadyout !== 1'b1);
	endtask

	// One single transfer of size sz: address phase, then data phase
	task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
		input logic [2:0] sz, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, ofs};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= sz;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? wd : 32'h00000000;
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, ofs, d, HSIZE_WORD, x);
	endtask

	task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
		logic [31:0] x;
		ahb(1'b0, ofs, 32'h00000000, HSIZE_WORD, x);
		check(x, exp);
		check({31'h00000000, hresp}, {31'h00000000, HRESP_OKAY});
	endtask

	// Isolate first, then apply enables, selects and far-side drive
	task automatic mode(input logic [1:0] ab, input logic [1:0] ban, input logic [1:0] sab,
		input logic [1:0] sba, input logic [1:0] ad, input logic [1:0] bd,
		input logic [15:0] av, input logic [15:0] bv);
		@(posedge hclk);
		oe_ab <= 2'h0;
		oe_ba_n <= 2'h3;
		a_drv <= 2'h0;
		b_drv <= 2'h0;
		repeat (2) @(posedge hclk);
		oe_ab <= ab;
		oe_ba_n <= ban;
		sel_ab <= sab;
		sel_ba <= sba;
		a_drv <= ad;
		b_drv <= bd;
		a_val <= av;
		b_val <= bv;
		repeat (3) @(posedge hclk);
		#1;
	endtask

	// Capture clock pulse, high for two cycles and low for three
	task automatic cap(input logic [1:0] ca, input logic [1:0] cb);
		@(posedge hclk);
		cap_a <= ca;
		cap_b <= cb;
		repeat (2) @(posedge hclk);
		cap_a <= 2'h0;
		cap_b <= 2'h0;
		repeat (3) @(posedge hclk);
		#1;
	endtask

	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		#1;
		check({28'h0000000, a_oe, b_oe}, 32'h00000000);
		rd(OFS_AREG, 32'h00000000);
		rd(OFS_BREG, 32'h00000000);
		$display("test reset done");
		mode(2'h0, 2'h3, 2'h0, 2'h0, 2'h3, 2'h3, 16'hA55A, 16'h3CC3);
		cap(2'h3, 2'h0);
		check({28'h0000000, a_oe, b_oe}, 32'h00000000);
		rd(OFS_AREG, 32'h0000A55A);
		rd(OFS_BREG, 32'h00000000);
		cap(2'h0, 2'h3);
		rd(OFS_BREG, 32'h00003CC3);
		rd(OFS_AREG, 32'h0000A55A);
		$display("test isolated capture done");
		mode(2'h3, 2'h3, 2'h0, 2'h0, 2'h3, 2'h0, 16'h1234, 16'h0000);
		check({28'h0000000, a_oe, b_oe}, 32'h00000003);
		check({16'h0000, b_out}, 32'h00001234);
		mode(2'h3, 2'h3, 2'h3, 2'h0, 2'h3, 2'h0, 16'h5AA5, 16'h0000);
		check({16'h0000, b_out}, 32'h0000A55A);
		cap(2'h3, 2'h0);
		check({16'h0000, b_out}, 32'h00005AA5);
		$display("test a to b done");
		mode(2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 16'h0000, 16'h00FF);
		check({28'h0000000, a_oe, b_oe}, 32'h0000000C);
		check({16'h0000, a_out}, 32'h000000FF);
		mode(2'h0, 2'h0, 2'h0, 2'h3, 2'h0, 2'h3, 16'h0000, 16'h00FF);
		check({16'h0000, a_out}, 32'h00003CC3);
		$display("test b to a done");
		mode(2'h3, 2'h0, 2'h3, 2'h3, 2'h0, 2'h0, 16'h0000, 16'h0000);
		check({a_out, b_out}, 32'h3CC35AA5);
		check({28'h0000000, a_oe, b_oe}, 32'h0000000F);
		mode(2'h1, 2'h1, 2'h0, 2'h0, 2'h1, 2'h2, 16'h0077, 16'h6600);
		check({28'h0000000, a_oe, b_oe}, 32'h00000009);
		check({16'h0000, a_out[15:8], b_out[7:0]}, 32'h00006677);
		$display("test both and halves done");
		mode(2'h0, 2'h3, 2'h0, 2'h0, 2'h3, 2'h3, 16'h0F0F, 16'hF0F0);
		cap(2'h3, 2'h3);
		rd(OFS_AREG, 32'h00000F0F);
		rd(OFS_BREG, 32'h0000F0F0);
		$display("test joint capture done");
		mode(2'h3, 2'h3, 2'h0, 2'h0, 2'h3, 2'h0, 16'h0F0F, 16'h0000);
		wr(OFS_CTRL, 32'h00000001);
		rd(OFS_STAT, 32'h00000010);
		rd(OFS_CTRL, 32'h00000001);
		wr(OFS_CTRL, 32'h00000000);
		repeat (2) @(posedge hclk);
		rd(OFS_STAT, 32'h0000000C);
		// A byte-sized write must leave the control word alone
		ahb(1'b1, OFS_CTRL, 32'h00000001, 3'h0, scratch);
		rd(OFS_CTRL, 32'h00000000);
		rd(8'h20, 32'h00000000);
		$display("test register window done");
		mode(2'h0, 2'h3, 2'h0, 2'h0, 2'h3, 2'h3, 16'h1357, 16'h2468);
		wr(OFS_CAPT, 32'h0000000F);
		rd(OFS_AREG, 32'h00001357);
		rd(OFS_BREG, 32'h00002468);
		$display("test soft capture done");
		// Reset again with both stores loaded
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		#1;
		check({28'h0000000, a_oe, b_oe}, 32'h00000000);
		rd(OFS_AREG, 32'h00000000);
		rd(OFS_BREG, 32'h00000000);
		$display("test second reset done");
		print_verdict();
	end
endmodule
`default_nettype wire
